// ---- rtl/cpu_pll_regs.sv ----
// Serial management slave and processor PLL divider and spread register bank.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_pll_consts.svh"

// Notes on behaviour
// RL1 - Byte 10 bit 7 enables programmed dividers for both PLLs; resets to zero.
// RL2 - Byte 11 low six bits are reference divider; byte 12 is feedback low byte.
// RL3 - Byte 11 bit 7 is feedback bit 8, bit 6 is feedback bit 9.
// RL4 - VCO equals 14.318 MHz times feedback term over reference term.
// RL5 - Bytes 11 and 12 steer the processor PLL only, never the auxiliary PLL.
// RL6 - Bytes 13 and 14 hold a 15-bit spread value; byte 14 bit 7 reads zero.
// RL7 - The spread value sets the processor clock spread percentage.
// RL8 - After reset divider fields load from the strap-selected table entry.
// RL9 - Feedback term is field plus eight; reference term is field plus two.
module cpu_pll_regs
  import cpu_pll_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT,
  parameter logic [79:0] STRAP_FB_TABLE = {8{10'h0c0}},
  parameter logic [47:0] STRAP_REF_TABLE = {8{6'h0c}},
  parameter logic [14:0] SPREAD_DEFAULT = 15'h0000
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Serial management pins
  input wire logic scl_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Frequency select straps
  input wire logic [2:0] freq_sel_strap,
  // PLL programming controls
  output logic mn_prog_en,
  output logic aux_mn_prog_en,
  output logic [9:0] cpu_fb_div,
  output logic [5:0] cpu_ref_div,
  output logic [10:0] cpu_fb_term,
  output logic [6:0] cpu_ref_term,
  output logic [23:0] cpu_vco_num_khz,
  output logic [14:0] spread_amount
);
  logic [4:0] sync_q;
  logic [2:0] fs_s;
  logic scl_s, sda_s, scl_d_reg, sda_d_reg;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  smb_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  reg_byte_t shift_reg, ptr_reg, rdata;
  logic rw_reg, drive_reg, wr_pulse_reg;
  reg_byte_t wr_addr_reg, wr_data_reg;
  logic [1:0] settle_cnt_reg;
  logic strap_load_reg, strap_done_reg;
  reg_byte_t rsvd_reg, enable_byte_reg;
  logic [9:0] fb_reg, strap_fb_reg, sel_fb;
  logic [5:0] ref_reg, strap_ref_reg, sel_ref;
  logic [14:0] spread_reg;

  // Table lookups indexed by the strap value.
  function automatic logic [9:0] strap_fb(input logic [2:0] sel);
    strap_fb = STRAP_FB_TABLE[sel*10 +: 10];
  endfunction
  function automatic logic [5:0] strap_ref(input logic [2:0] sel);
    strap_ref = STRAP_REF_TABLE[sel*6 +: 6];
  endfunction

  // All pins cross into the system clock through two flops.
  pin_sync #(.W(5)) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .d_in({freq_sel_strap, scl_pin, sda_in}),
    .q_out(sync_q)
  );
  assign fs_s = sync_q[4:2];
  assign scl_s = sync_q[1];
  assign sda_s = sync_q[0];

  // Previous samples for edge and condition detection.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end
  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;
  assign bus_start = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign bus_stop = scl_s && scl_d_reg && !sda_d_reg && sda_s;

  // Read mux; unmapped offsets answer zero so the host can scan freely.
  always_comb begin
    case (ptr_reg)
      `REG_RESERVED_BYTE: rdata = rsvd_reg;
      `REG_DIV_PROG_ENABLE: rdata = enable_byte_reg;
      // RL3 swapped upper bits
      `REG_REF_DIV_FB_HIGH: rdata = {fb_reg[8], fb_reg[9], ref_reg};
      `REG_FB_DIV_LOW: rdata = fb_reg[7:0];
      `REG_SPREAD_LOW: rdata = spread_reg[7:0];
      // RL6 reserved bit zero
      `REG_SPREAD_HIGH: rdata = {1'b0, spread_reg[14:8]};
      default: rdata = `UNMAPPED_READ;
    endcase
  end

  // Serial protocol engine: address, command pointer, then data with auto-increment.
  // The data line only changes on a falling clock so the host never sees a false stop.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      drive_reg <= 1'b0;
      wr_pulse_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
    end else begin
      wr_pulse_reg <= 1'b0;
      if (bus_start) begin
        state_reg <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        drive_reg <= 1'b0;
      end else if (bus_stop) begin
        state_reg <= ST_IDLE;
        drive_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_ADDR, ST_CMD, ST_WDATA: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'h8) begin
              bit_cnt_reg <= 4'h0;
              if (state_reg == ST_ADDR) begin
                if (shift_reg[7:1] == DEV_ADDR) begin
                  rw_reg <= shift_reg[0];
                  drive_reg <= 1'b1;
                  state_reg <= ST_ADDR_ACK;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end else if (state_reg == ST_CMD) begin
                ptr_reg <= shift_reg;
                drive_reg <= 1'b1;
                state_reg <= ST_CMD_ACK;
              end else begin
                wr_pulse_reg <= 1'b1;
                wr_addr_reg <= ptr_reg;
                wr_data_reg <= shift_reg;
                drive_reg <= 1'b1;
                state_reg <= ST_WDATA_ACK;
              end
            end
          end
          ST_ADDR_ACK: begin
            if (scl_fall) begin
              if (rw_reg) begin
                shift_reg <= rdata;
                drive_reg <= !rdata[7];
                state_reg <= ST_RDATA;
              end else begin
                drive_reg <= 1'b0;
                state_reg <= ST_CMD;
              end
            end
          end
          ST_CMD_ACK, ST_WDATA_ACK: begin
            if (scl_fall) begin
              drive_reg <= 1'b0;
              if (state_reg == ST_WDATA_ACK) begin
                ptr_reg <= ptr_reg + 8'h01;
              end
              state_reg <= ST_WDATA;
            end
          end
          ST_RDATA: begin
            if (scl_rise) begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt_reg == 4'h8) begin
                drive_reg <= 1'b0;
                ptr_reg <= ptr_reg + 8'h01;
                state_reg <= ST_RDATA_ACK;
              end else begin
                shift_reg <= {shift_reg[6:0], 1'b0};
                drive_reg <= !shift_reg[6];
              end
            end
          end
          ST_RDATA_ACK: begin
            if (scl_rise) begin
              rw_reg <= !sda_s; // Host acknowledge means keep reading.
            end else if (scl_fall) begin
              bit_cnt_reg <= 4'h0;
              if (rw_reg) begin
                shift_reg <= rdata;
                drive_reg <= !rdata[7];
                state_reg <= ST_RDATA;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_IDLE: drive_reg <= 1'b0;
          default: begin
            drive_reg <= 1'b0;
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end
  assign sda_out = 1'b0;
  assign sda_oe = drive_reg;

  // RL8 strap settle then load
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      settle_cnt_reg <= 2'h0;
      strap_load_reg <= 1'b0;
      strap_done_reg <= 1'b0;
    end else begin
      strap_load_reg <= 1'b0;
      if (!strap_done_reg) begin
        if (settle_cnt_reg == `STRAP_SETTLE_CYCLES) begin
          strap_load_reg <= 1'b1;
          strap_done_reg <= 1'b1;
        end else begin
          settle_cnt_reg <= settle_cnt_reg + 2'h1;
        end
      end
    end
  end

  // RL1 enable byte storage
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rsvd_reg <= `RESERVED_BYTE_RST;
      enable_byte_reg <= `DIV_PROG_ENABLE_RST;
    end else if (wr_pulse_reg) begin
      if (wr_addr_reg == `REG_RESERVED_BYTE) begin
        rsvd_reg <= wr_data_reg;
      end
      if (wr_addr_reg == `REG_DIV_PROG_ENABLE) begin
        enable_byte_reg <= wr_data_reg;
      end
    end
  end
  assign mn_prog_en = enable_byte_reg[`DIV_PROG_EN_BIT];
  assign aux_mn_prog_en = enable_byte_reg[`DIV_PROG_EN_BIT];

  // RL2 divider fields; the strap load only happens long before any host write.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      fb_reg <= 10'h000;
      ref_reg <= 6'h00;
      strap_fb_reg <= 10'h000;
      strap_ref_reg <= 6'h00;
    end else if (strap_load_reg) begin
      // RL8 strap table entry
      fb_reg <= strap_fb(fs_s);
      ref_reg <= strap_ref(fs_s);
      strap_fb_reg <= strap_fb(fs_s);
      strap_ref_reg <= strap_ref(fs_s);
    end else if (wr_pulse_reg) begin
      if (wr_addr_reg == `REG_REF_DIV_FB_HIGH) begin
        ref_reg <= wr_data_reg[5:0];
        // RL3 swapped bit order
        fb_reg[8] <= wr_data_reg[`FB_BIT8_POS];
        fb_reg[9] <= wr_data_reg[`FB_BIT9_POS];
      end
      if (wr_addr_reg == `REG_FB_DIV_LOW) begin
        fb_reg[7:0] <= wr_data_reg;
      end
    end
  end
  assign cpu_fb_div = fb_reg;
  assign cpu_ref_div = ref_reg;

  // RL6 spread value storage
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      spread_reg <= 15'h0000;
    end else if (strap_load_reg) begin
      spread_reg <= SPREAD_DEFAULT;
    end else if (wr_pulse_reg) begin
      if (wr_addr_reg == `REG_SPREAD_LOW) begin
        spread_reg[7:0] <= wr_data_reg;
      end
      if (wr_addr_reg == `REG_SPREAD_HIGH) begin
        spread_reg[14:8] <= wr_data_reg[6:0];
      end
    end
  end
  // RL7 spread to processor outputs
  assign spread_amount = spread_reg;

  // RL5 processor PLL only; the auxiliary PLL sees just the enable.
  assign sel_fb = mn_prog_en ? fb_reg : strap_fb_reg;
  assign sel_ref = mn_prog_en ? ref_reg : strap_ref_reg;

  // RL9 term offsets, registered to keep the PLL inputs glitch free
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cpu_fb_term <= `FB_TERM_OFFSET;
      cpu_ref_term <= `REF_TERM_OFFSET;
    end else begin
      cpu_fb_term <= {1'b0, sel_fb} + `FB_TERM_OFFSET;
      cpu_ref_term <= {1'b0, sel_ref} + `REF_TERM_OFFSET;
    end
  end

  // RL4 VCO numerator in kHz; the PLL divides it by the reference term.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cpu_vco_num_khz <= 24'h000000;
    end else begin
      cpu_vco_num_khz <= 24'(cpu_fb_term * `REF_CLK_KHZ);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_enable_write: assert property (wr_pulse_reg && wr_addr_reg == `REG_DIV_PROG_ENABLE
    |=> mn_prog_en == $past(wr_data_reg[7]) && aux_mn_prog_en == mn_prog_en) // RL1
    else $error("Divider enable does not follow its write.");
  a_ref_field: assert property (wr_pulse_reg && !strap_load_reg
    && wr_addr_reg == `REG_REF_DIV_FB_HIGH |=> cpu_ref_div == $past(wr_data_reg[5:0])) // RL2
    else $error("Reference divider field not written.");
  a_fb_swap: assert property (wr_pulse_reg && !strap_load_reg
    && wr_addr_reg == `REG_REF_DIV_FB_HIGH
    |=> cpu_fb_div[9] == $past(wr_data_reg[6]) && cpu_fb_div[8] == $past(wr_data_reg[7])) // RL3
    else $error("Upper feedback bits not swapped.");
  a_vco_value: assert property (mn_prog_en && $stable(fb_reg) && $stable(mn_prog_en)
    |=> ##1 cpu_vco_num_khz == 24'($past(fb_reg, 2) + 10'h008) * 24'h0037ee) // RL4
    else $error("VCO numerator wrong.");
  a_aux_untouched: assert property (wr_pulse_reg && wr_addr_reg == `REG_FB_DIV_LOW
    |=> $stable(aux_mn_prog_en)) // RL5
    else $error("Auxiliary PLL disturbed by processor divider write.");
  a_spread_high: assert property (wr_pulse_reg && !strap_load_reg
    && wr_addr_reg == `REG_SPREAD_HIGH
    |=> spread_amount[14:8] == $past(wr_data_reg[6:0])) // RL6
    else $error("Spread high bits not written.");
  a_spread_rsvd: assert property (ptr_reg == `REG_SPREAD_HIGH |-> rdata[7] == 1'b0) // RL6
    else $error("Reserved spread bit reads one.");
  a_spread_low: assert property (wr_pulse_reg && !strap_load_reg
    && wr_addr_reg == `REG_SPREAD_LOW |=> spread_amount[7:0] == $past(wr_data_reg)) // RL7
    else $error("Spread low bits not written.");
  a_strap_load: assert property (strap_load_reg
    |=> cpu_fb_div == strap_fb($past(fs_s)) && cpu_ref_div == strap_ref($past(fs_s))) // RL8
    else $error("Strap defaults not loaded.");
  a_term_offset: assert property (!mn_prog_en && $stable(strap_fb_reg)
    |=> cpu_fb_term == {1'b0, $past(strap_fb_reg)} + 11'h008) // RL9
    else $error("Feedback term offset wrong.");
  a_ref_offset: assert property (mn_prog_en && $stable(mn_prog_en)
    |=> cpu_ref_term == {1'b0, $past(ref_reg)} + 7'h02) // RL9
    else $error("Reference term offset wrong.");

  c_div_write: cover property (wr_pulse_reg && wr_addr_reg == `REG_REF_DIV_FB_HIGH);
  c_enable_on: cover property (wr_pulse_reg && wr_addr_reg == `REG_DIV_PROG_ENABLE
    && wr_data_reg[7]);
  c_read_back: cover property (state_reg == ST_RDATA_ACK && scl_fall && rw_reg);
  c_strap: cover property (strap_load_reg);
endmodule
`default_nettype wire

// ---- inc/cpu_pll_consts.svh ----
// Register offsets, field positions, reset values and counts of the processor PLL register bank.
`ifndef CPU_PLL_CONSTS_SVH
`define CPU_PLL_CONSTS_SVH

`define REG_RESERVED_BYTE 8'h09
`define REG_DIV_PROG_ENABLE 8'h0a
`define REG_REF_DIV_FB_HIGH 8'h0b
`define REG_FB_DIV_LOW 8'h0c
`define REG_SPREAD_LOW 8'h0d
`define REG_SPREAD_HIGH 8'h0e

`define RESERVED_BYTE_RST 8'h00
`define DIV_PROG_ENABLE_RST 8'h00
`define UNMAPPED_READ 8'h00

`define DIV_PROG_EN_BIT 7
`define FB_BIT8_POS 7
`define FB_BIT9_POS 6
`define SPREAD_HIGH_RSVD_BIT 7

`define FB_TERM_OFFSET 11'h008
`define REF_TERM_OFFSET 7'h02
`define REF_CLK_KHZ 14'h37ee

`define STRAP_SETTLE_CYCLES 2'h3
`define DEV_ADDR_DEFAULT 7'h5a

`endif

// ---- inc/cpu_pll_pkg.sv ----
// Types shared by the processor PLL register bank.
package cpu_pll_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_ADDR      = 4'h1,
    ST_ADDR_ACK  = 4'h3,
    ST_CMD       = 4'h2,
    ST_CMD_ACK   = 4'h6,
    ST_WDATA     = 4'h7,
    ST_WDATA_ACK = 4'h5,
    ST_RDATA     = 4'h4,
    ST_RDATA_ACK = 4'hc
  } smb_state_t;
endpackage

// ---- rtl/pin_sync.sv ----
// Two-stage synchroniser for asynchronous pin inputs.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Pins and synchronised copies
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      meta_reg <= '0;
      q_out <= '0;
    end else begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ---- verif/smb_host_model.sv ----
// Serial management host model driving the clock and data pins of the register bank.
`timescale 1ns/1ps
`default_nettype none
module smb_host_model #(
  parameter int HALF = 20
) (
  // Clock
  input wire logic clk_sys,
  // Bus pins
  input wire logic sda_line,
  output var logic scl,
  output var logic sda_drv
);
  // Both lines rest released; the pull-up holds them high between frames.
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic hold();
    repeat (HALF) @(posedge clk_sys);
  endtask

  // Start or repeated start: data falls while the clock is high.
  task automatic start_cond();
    sda_drv <= 1'b1;
    hold();
    scl <= 1'b1;
    hold();
    sda_drv <= 1'b0;
    hold();
    scl <= 1'b0;
    hold();
  endtask

  // Stop: data rises while the clock is high.
  task automatic stop_cond();
    sda_drv <= 1'b0;
    hold();
    scl <= 1'b1;
    hold();
    sda_drv <= 1'b1;
    hold();
  endtask

  // Data is held past the falling clock, since the device sees both pins through the same
  // synchroniser delay and a simultaneous change could read as a start or stop.
  task automatic bit_cycle(input logic b, output logic seen);
    sda_drv <= b;
    hold();
    scl <= 1'b1;
    repeat (HALF / 2) @(posedge clk_sys);
    seen = sda_line;
    repeat (HALF / 2) @(posedge clk_sys);
    scl <= 1'b0;
    repeat (HALF / 4) @(posedge clk_sys);
  endtask

  // Byte out, first bit most significant, then the acknowledge slot released.
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(d[i], s);
    end
    bit_cycle(1'b1, ack);
  endtask

  // Byte in, then the host's own acknowledge or refusal.
  task automatic recv_byte(output logic [7:0] d, input logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, s);
      d[i] = s;
    end
    bit_cycle(nack, s);
  endtask
endmodule
`default_nettype wire

// ---- verif/test_cpu_pll_divider_spread_regs.sv ----
// Self-checking testbench of the processor PLL register bank.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_pll_consts.svh"
module test_cpu_pll_divider_spread_regs;
  import cpu_pll_pkg::*;
  localparam logic [79:0] FB_TBL = {10'h0c7, 10'h0c6, 10'h0c5, 10'h0c4, 10'h0c3, 10'h0c2,
    10'h0c1, 10'h0c0};
  localparam logic [47:0] REF_TBL = {6'h13, 6'h12, 6'h11, 6'h10, 6'h0f, 6'h0e, 6'h0d, 6'h0c};
  localparam logic [14:0] SPR_DEF = 15'h1234;
  localparam logic [2:0] STRAP = 3'h5;
  localparam logic [6:0] DEV = `DEV_ADDR_DEFAULT;
  localparam logic [9:0] S_FB = FB_TBL[STRAP*10 +: 10];
  localparam logic [5:0] S_REF = REF_TBL[STRAP*6 +: 6];
  logic clk_sys, nrst, scl, host_sda, sda_line, sda_out, sda_oe;
  logic mn_prog_en, aux_mn_prog_en;
  logic [2:0] freq_sel_strap;
  logic [9:0] cpu_fb_div;
  logic [5:0] cpu_ref_div;
  logic [10:0] cpu_fb_term;
  logic [6:0] cpu_ref_term;
  logic [23:0] cpu_vco_num_khz;
  logic [14:0] spread_amount;
  int n_errors = 0;
  int check_count = 0;

  // Open-drain data wire with pull-up: low whenever either party pulls it.
  assign sda_line = sda_oe ? sda_out : host_sda;

  cpu_pll_regs #(.STRAP_FB_TABLE(FB_TBL), .STRAP_REF_TABLE(REF_TBL),
    .SPREAD_DEFAULT(SPR_DEF)) dut (.clk_sys(clk_sys), .nrst(nrst), .scl_pin(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .freq_sel_strap(freq_sel_strap),
    .mn_prog_en(mn_prog_en), .aux_mn_prog_en(aux_mn_prog_en), .cpu_fb_div(cpu_fb_div),
    .cpu_ref_div(cpu_ref_div), .cpu_fb_term(cpu_fb_term), .cpu_ref_term(cpu_ref_term),
    .cpu_vco_num_khz(cpu_vco_num_khz), .spread_amount(spread_amount));

  smb_host_model host (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_drv(host_sda));

  // Clock of 5 ns period.
  initial clk_sys = 1'b0;
  always #2.5 clk_sys = ~clk_sys;

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Write a burst starting at one offset; a refused address sends nothing further.
  task automatic wr(input logic [6:0] dev, input reg_byte_t off, input reg_byte_t d[$],
    input logic exp_ack);
    logic a;
    host.start_cond();
    host.send_byte({dev, 1'b0}, a);
    chk("address ack", a, exp_ack);
    if (a === 1'b0) begin
      host.send_byte(off, a);
      chk("offset ack", a, 0);
      foreach (d[i]) begin
        host.send_byte(d[i], a);
        chk("data ack", a, 0);
      end
    end
    host.stop_cond();
    repeat (8) @(posedge clk_sys);
  endtask

  // Read a burst through a repeated start, refusing only the last byte.
  task automatic rd(input reg_byte_t off, input reg_byte_t e[$]);
    logic a;
    reg_byte_t v;
    host.start_cond();
    host.send_byte({DEV, 1'b0}, a);
    host.send_byte(off, a);
    host.start_cond();
    host.send_byte({DEV, 1'b1}, a);
    foreach (e[i]) begin
      host.recv_byte(v, i == e.size() - 1);
      chk("read byte", v, e[i]);
    end
    host.stop_cond();
    repeat (8) @(posedge clk_sys);
  endtask

  // Terms follow the strap entry while disabled and the fields while enabled.
  task automatic chk_pll(input logic [9:0] fb, input logic [5:0] rf, input logic en);
    logic [10:0] ft;
    logic [6:0] rt;
    ft = (en ? fb : S_FB) + 11'h008;
    rt = (en ? rf : S_REF) + 7'h02;
    chk("enable", mn_prog_en, en);
    chk("aux enable", aux_mn_prog_en, en);
    chk("fb field", cpu_fb_div, fb);
    chk("ref field", cpu_ref_div, rf);
    chk("fb term", cpu_fb_term, ft);
    chk("ref term", cpu_ref_term, rt);
    chk("vco", cpu_vco_num_khz, 32'(ft) * 32'(`REF_CLK_KHZ));
  endtask

  task automatic t_reset();
    chk_pll(S_FB, S_REF, 1'b0);
    chk("spread", spread_amount, SPR_DEF);
    rd(`REG_RESERVED_BYTE, {8'h00, 8'h00});
  endtask

  // Upper feedback bits arrive swapped; the reserved spread bit is written 1 but reads 0.
  task automatic t_program();
    wr(DEV, `REG_DIV_PROG_ENABLE, {8'h80, 8'h8b, 8'h34, 8'h56, 8'hff}, 1'b0);
    chk_pll(10'h134, 6'h0b, 1'b1);
    chk("spread", spread_amount, 15'h7f56);
    rd(`REG_DIV_PROG_ENABLE, {8'h80, 8'h8b, 8'h34, 8'h56, 8'h7f});
  endtask

  task automatic t_swap();
    wr(DEV, `REG_REF_DIV_FB_HIGH, {8'h40}, 1'b0);
    chk_pll(10'h234, 6'h00, 1'b1);
  endtask

  // Wrong address, reserved byte and unmapped offset leave the dividers alone.
  task automatic t_refuse();
    wr(7'h5b, `REG_REF_DIV_FB_HIGH, {8'hff}, 1'b1);
    wr(DEV, `REG_RESERVED_BYTE, {8'ha5}, 1'b0);
    rd(`REG_RESERVED_BYTE, {8'ha5});
    wr(DEV, 8'h20, {8'h33}, 1'b0);
    rd(8'h20, {8'h00});
    chk_pll(10'h234, 6'h00, 1'b1);
  endtask

  task automatic t_disable();
    wr(DEV, `REG_DIV_PROG_ENABLE, {8'h00}, 1'b0);
    chk_pll(10'h234, 6'h00, 1'b0);
  endtask

  // Reset for 12 cycles, let the strap load settle, then run every scenario.
  initial begin
    nrst = 1'b0;
    freq_sel_strap = STRAP;
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (20) @(posedge clk_sys);
    t_reset();
    t_program();
    t_swap();
    t_refuse();
    t_disable();
    stop_test();
  end

  // A hang is cut short well beyond the expected run of about 18400 cycles.
  initial begin
    repeat (90000) @(posedge clk_sys);
    n_errors++;
    $display("Watchdog expired");
    stop_test();
  end
endmodule
`default_nettype wire
